// ---- core/srm_regs.svh ----
// Register selectors, bit positions and reset values of the status reporting block
`ifndef SRM_REGS_SVH
`define SRM_REGS_SVH
`define SRM_SEL_STB     3'h0
`define SRM_SEL_SVCMASK 3'h1
`define SRM_SEL_STDEV   3'h2
`define SRM_SEL_ESE     3'h3
`define SRM_SEL_CESR    3'h4
`define SRM_SEL_CEEN    3'h5
`define SRM_SEL_OVSR    3'h6
`define SRM_SEL_OVEN    3'h7
`define SRM_BIT_OVL     3'h0
`define SRM_BIT_IDLE    3'h4
`define SRM_BIT_EVT     3'h5
`define SRM_BIT_MSS     3'h6
`define SRM_BIT_CERR    3'h7
`define SRM_SVC_WMASK   8'hBF
`define SRM_ZERO8       8'h00
`define SRM_TERM_RST    3'h3
`define SRM_TERM_MAX    3'h4
`define SRM_TOKEN_RST   1'b0
`define SRM_CR          8'h0D
`define SRM_LF          8'h0A
`endif

// ---- core/srm_pkg.sv ----
// Types shared by the status reporting block
package srm_pkg;
    typedef enum logic [2:0] {
        SRM_TERM_NONE = 3'h0,
        SRM_TERM_CR   = 3'h1,
        SRM_TERM_LF   = 3'h2,
        SRM_TERM_CRLF = 3'h3,
        SRM_TERM_LFCR = 3'h4
    } srm_term_e;
    typedef logic [7:0] srm_byte_t;
endpackage

// ---- core/srm_status_model.sv ----
// Hierarchical status model with service request line and response format settings
`timescale 1ns/1ps
`default_nettype none
`include "srm_regs.svh"
module srm_status_model #(
    parameter int OVL_BITS = 8                // Width of overload condition set
) (
    input  wire logic                core_clk,          // 200 MHz clock
    input  wire logic                srst,              // Synchronous reset, high
    input  wire logic                wr_en,             // Write pulse from parser
    input  wire logic                rd_en,             // Whole-register query pulse
    input  wire logic                rd_bit_en,         // Single-bit query pulse
    input  wire logic [2:0]          reg_sel,           // Register selector
    input  wire logic [2:0]          bit_sel,           // Bit index for bit query
    input  wire logic [7:0]          wr_data,           // Write data
    output logic [7:0]               rd_data,           // Query answer (registered)
    input  wire logic                cls_cmd,           // Clear-status command pulse
    input  wire logic                opc_cmd,           // Operation-complete pulse
    input  wire logic                input_discard_flag,// Input data discarded pulse
    input  wire logic                query_lost,        // Output queue data lost pulse
    input  wire logic                dev_err,           // Delayed execution error pulse
    input  wire logic                exec_err,          // Parsed command error pulse
    input  wire logic                cmd_err,           // Parser error pulse
    input  wire logic                button_press,      // Front-panel button pulse
    input  wire logic                power_on_evt,      // Off-to-on transition pulse
    input  wire logic [7:0]          comm_err_evt,      // Comm error event pulses
    input  wire logic [OVL_BITS-1:0] ovl_cond,          // Live overload conditions
    input  wire logic                in_buf_empty,      // Input buffer empty
    input  wire logic                parser_idle,       // Command parser idle
    input  wire logic                token_mode_wr,     // Token mode write pulse
    input  wire logic                token_mode_val,    // Token mode value
    input  wire logic                term_wr,           // Terminator write pulse
    input  wire logic [2:0]          term_val,          // Terminator code
    output logic                     token_keyword_mode,// Keyword answers when high
    output logic [1:0]               term_len,          // Terminator length in chars
    output logic [7:0]               term_char0,        // First terminator char
    output logic [7:0]               term_char1,        // Second terminator char
    output logic [7:0]               status_summary_byte,// Live status byte
    output logic                     overload_summary_bit,// Overload summary
    output logic                     comm_error_summary_bit,// Comm error summary
    output logic                     status_req_n       // Service request, low active
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]          service_request_mask_q;
    logic [7:0]          standard_event_flags_q;
    logic [7:0]          std_event_enable_q;
    logic [7:0]          comm_err_flags_q;
    logic [7:0]          comm_error_enable_q;
    logic [OVL_BITS-1:0] ovl_flags_q;
    logic [OVL_BITS-1:0] overload_enable_q;
    logic [OVL_BITS-1:0] ovl_cond_q;
    logic                token_mode_q;
    srm_pkg::srm_term_e  term_q;
    logic                req_q;
    logic [7:0]          svc_prev_q;
    logic [7:0]          std_set;
    logic [7:0]          sel_mask;
    logic [7:0]          svc_bits;
    logic                event_summary_bit;
    logic                mss;
    logic [7:0]          ovl_rd;
    logic [7:0]          ovl_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Clear mask for the selected register: whole query, bit query or clear-status
    function automatic logic [7:0] clr_of(input logic [2:0] sel);
        logic [7:0] m;
        m = `SRM_ZERO8;
        if (rd_en && reg_sel == sel) begin
            m = 8'hFF;
        end else if (rd_bit_en && reg_sel == sel) begin
            m = 8'h01 << bit_sel;
        end
        if (cls_cmd) begin
            m = 8'hFF;
        end
        return m;
    endfunction

    assign std_set = {power_on_evt, button_press, cmd_err, exec_err,
                      dev_err, query_lost, input_discard_flag, opc_cmd};

    // Set wins over clear so an event landing with its query is kept
    always_ff @(posedge core_clk) begin
        if (srst) begin
            standard_event_flags_q <= `SRM_ZERO8;
        end else begin
            standard_event_flags_q <= (standard_event_flags_q & ~clr_of(`SRM_SEL_STDEV))
                                      | std_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            comm_err_flags_q <= `SRM_ZERO8;
        end else begin
            comm_err_flags_q <= (comm_err_flags_q & ~clr_of(`SRM_SEL_CESR))
                                | comm_err_evt;
        end
    end

    always_comb begin
        ovl_clr = clr_of(`SRM_SEL_OVSR);
    end

    // Overload events latch on rising edges of the live conditions
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ovl_cond_q  <= '0;
            ovl_flags_q <= '0;
        end else begin
            ovl_cond_q  <= ovl_cond;
            ovl_flags_q <= (ovl_flags_q & ~ovl_clr[OVL_BITS-1:0])
                           | (ovl_cond & ~ovl_cond_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (srst) begin
            service_request_mask_q <= `SRM_ZERO8;
            std_event_enable_q     <= `SRM_ZERO8;
            comm_error_enable_q    <= `SRM_ZERO8;
            overload_enable_q      <= '0;
        end else if (wr_en) begin
            unique case (reg_sel)
                `SRM_SEL_SVCMASK: service_request_mask_q <= wr_data & `SRM_SVC_WMASK;
                `SRM_SEL_ESE:     std_event_enable_q <= wr_data;
                `SRM_SEL_CEEN:    comm_error_enable_q <= wr_data;
                `SRM_SEL_OVEN:    overload_enable_q <= wr_data[OVL_BITS-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            token_mode_q <= `SRM_TOKEN_RST;
            term_q <= srm_pkg::srm_term_e'(`SRM_TERM_RST);
        end else begin
            if (token_mode_wr) begin
                token_mode_q <= token_mode_val;
            end
            if (term_wr && term_val <= `SRM_TERM_MAX) begin
                term_q <= srm_pkg::srm_term_e'(term_val);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summaries are combinational so the byte always shows the masked state
    assign overload_summary_bit   = |(ovl_flags_q & overload_enable_q);
    assign event_summary_bit      = |(standard_event_flags_q & std_event_enable_q);
    assign comm_error_summary_bit = |(comm_err_flags_q & comm_error_enable_q);

    always_comb begin
        svc_bits = `SRM_ZERO8;
        svc_bits[`SRM_BIT_OVL]  = overload_summary_bit;
        svc_bits[`SRM_BIT_IDLE] = in_buf_empty & parser_idle;
        svc_bits[`SRM_BIT_EVT]  = event_summary_bit;
        svc_bits[`SRM_BIT_CERR] = comm_error_summary_bit;
    end

    assign sel_mask = svc_bits & service_request_mask_q;
    assign mss      = |sel_mask;

    always_comb begin
        status_summary_byte = svc_bits;
        status_summary_byte[`SRM_BIT_MSS] = mss;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request re-arms only on a newly enabled bit, so a query releases it until another enabled bit rises
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_q      <= 1'b0;
            svc_prev_q <= `SRM_ZERO8;
        end else begin
            svc_prev_q <= sel_mask;
            if (|(sel_mask & ~svc_prev_q)) begin
                req_q <= 1'b1;
            end else if ((rd_en || rd_bit_en) && reg_sel == `SRM_SEL_STB) begin
                req_q <= 1'b0;
            end else if (!mss) begin
                req_q <= 1'b0;
            end
        end
    end

    assign status_req_n = ~req_q;

    ////////////////////////////////////////////////////////////////////////////
    assign ovl_rd = 8'(ovl_flags_q);

    // The status byte copy is live, and a query of it clears no event flags but releases the request line
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data <= `SRM_ZERO8;
        end else if (rd_en || rd_bit_en) begin
            unique case (reg_sel)
                `SRM_SEL_STB:     rd_data <= status_summary_byte;
                `SRM_SEL_SVCMASK: rd_data <= service_request_mask_q;
                `SRM_SEL_STDEV:   rd_data <= standard_event_flags_q;
                `SRM_SEL_ESE:     rd_data <= std_event_enable_q;
                `SRM_SEL_CESR:    rd_data <= comm_err_flags_q;
                `SRM_SEL_CEEN:    rd_data <= comm_error_enable_q;
                `SRM_SEL_OVSR:    rd_data <= ovl_rd;
                `SRM_SEL_OVEN:    rd_data <= 8'(overload_enable_q);
                default: ;
            endcase
        end
    end

    assign token_keyword_mode = token_mode_q;

    always_comb begin
        term_len   = 2'h0;
        term_char0 = `SRM_ZERO8;
        term_char1 = `SRM_ZERO8;
        unique case (term_q)
            srm_pkg::SRM_TERM_NONE: term_len = 2'h0;
            srm_pkg::SRM_TERM_CR: begin
                term_len = 2'h1;
                term_char0 = `SRM_CR;
            end
            srm_pkg::SRM_TERM_LF: begin
                term_len = 2'h1;
                term_char0 = `SRM_LF;
            end
            srm_pkg::SRM_TERM_CRLF: begin
                term_len = 2'h2;
                term_char0 = `SRM_CR;
                term_char1 = `SRM_LF;
            end
            srm_pkg::SRM_TERM_LFCR: begin
                term_len = 2'h2;
                term_char0 = `SRM_LF;
                term_char1 = `SRM_CR;
            end
            default: term_len = 2'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_TOKEN_RST: assert property (@(posedge core_clk)
        srst |=> !token_keyword_mode)
        else $error("token mode not off after reset");
    AST_TERM_RST: assert property (@(posedge core_clk)
        srst |=> term_len == 2'h2 && term_char0 == `SRM_CR && term_char1 == `SRM_LF)
        else $error("terminator not CRLF after reset");
    AST_OPC_SET: assert property (@(posedge core_clk) disable iff (srst)
        opc_cmd |=> standard_event_flags_q[0])
        else $error("operation complete flag not set");
    AST_MASK_B6: assert property (@(posedge core_clk) disable iff (srst)
        !service_request_mask_q[`SRM_BIT_MSS])
        else $error("request mask bit 6 set");
    AST_REQ_SET: assert property (@(posedge core_clk) disable iff (srst)
        (|(sel_mask & ~svc_prev_q)) |=> !status_req_n)
        else $error("request line not asserted");
    AST_REQ_NEEDS_MSS: assert property (@(posedge core_clk) disable iff (srst)
        !status_req_n |-> $past(mss))
        else $error("request low without master summary");
    AST_REQ_REL: assert property (@(posedge core_clk) disable iff (srst)
        ((rd_en || rd_bit_en) && reg_sel == `SRM_SEL_STB && !(|(sel_mask & ~svc_prev_q)))
        |=> status_req_n)
        else $error("request line not released by status query");
    AST_STB_KEEP: assert property (@(posedge core_clk) disable iff (srst)
        (rd_en && reg_sel == `SRM_SEL_STB && !cls_cmd && !(|std_set)) |=>
        $stable(standard_event_flags_q))
        else $error("status byte query cleared events");
    AST_STDEV_CLR: assert property (@(posedge core_clk) disable iff (srst)
        (rd_en && reg_sel == `SRM_SEL_STDEV && !(|std_set)) |=>
        standard_event_flags_q == `SRM_ZERO8)
        else $error("event query did not clear");
    AST_IDLE: assert property (@(posedge core_clk) disable iff (srst)
        status_summary_byte[`SRM_BIT_IDLE] == (in_buf_empty && parser_idle))
        else $error("idle bit wrong");
    AST_BYTE_GAPS: assert property (@(posedge core_clk) disable iff (srst)
        status_summary_byte[3:1] == 3'h0)
        else $error("status byte unused bits set");
endmodule
`default_nettype wire

// ---- verification/srm_host_model.sv ----
// Host controller model that issues register commands to the status block
`timescale 1ns/1ps
`default_nettype none
module srm_host_model (
    input  wire logic       core_clk,  // Block clock
    input  wire logic [7:0] rd_data,   // Query answer
    output logic            wr_en,     // Write strobe
    output logic            rd_en,     // Whole query strobe
    output logic            rd_bit_en, // Bit query strobe
    output logic [2:0]      reg_sel,   // Register selector
    output logic [2:0]      bit_sel,   // Bit index
    output logic [7:0]      wr_data,   // Write data
    output logic            cls_cmd,   // Clear-status strobe
    output logic            token_mode_wr,  // Token mode write
    output logic            token_mode_val, // Token mode value
    output logic            term_wr,   // Terminator write
    output logic [2:0]      term_val   // Terminator code
);
    initial begin
        {wr_en, rd_en, rd_bit_en, cls_cmd, token_mode_wr, term_wr} = 6'h00;
        {reg_sel, bit_sel, term_val, token_mode_val} = 10'h000;
        wr_data = 8'h00;
    end
    // Kind 0 write, 1 query, 2 bit query, 3 clear, 4 token mode, 5 terminator
    // One idle edge between commands keeps each strobe a clean single pulse
    task automatic issue(input int kind, input logic [2:0] sel, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge core_clk);
        #1;
        reg_sel   = sel;
        bit_sel   = d[2:0];
        wr_data   = d;
        token_mode_val = d[0];
        term_val  = d[2:0];
        wr_en     = (kind == 0);
        rd_en     = (kind == 1);
        rd_bit_en = (kind == 2);
        cls_cmd   = (kind == 3);
        token_mode_wr = (kind == 4);
        term_wr   = (kind == 5);
        @(posedge core_clk);
        #1;
        q = rd_data;
        {wr_en, rd_en, rd_bit_en, cls_cmd, token_mode_wr, term_wr} = 6'h00;
    endtask
endmodule
`default_nettype wire

// ---- verification/srm_status_model_tb_top.sv ----
// Self-checking testbench of the status reporting block
`timescale 1ns/1ps
`default_nettype none
`include "srm_regs.svh"
module srm_status_model_tb_top;
    logic        core_clk, srst, in_buf_empty, parser_idle;
    logic [7:0]  ev, comm_err_evt, ovl_cond, q, rd_data, wr_data, sb, ese;
    logic        wr_en, rd_en, rd_bit_en, cls_cmd, token_mode_wr, token_mode_val, term_wr;
    logic [2:0]  reg_sel, bit_sel, term_val, t;
    logic        token_keyword_mode, ovl_sum, cerr_sum, status_req_n;
    logic [1:0]  term_len;
    logic [7:0]  term_char0, term_char1;
    logic [31:0] lfsr;
    int          miscompares, n_compared, k;

    srm_status_model srm_status_model_i (.core_clk(core_clk), .srst(srst),
        .wr_en(wr_en), .rd_en(rd_en), .rd_bit_en(rd_bit_en), .reg_sel(reg_sel),
        .bit_sel(bit_sel), .wr_data(wr_data), .rd_data(rd_data), .cls_cmd(cls_cmd),
        .opc_cmd(ev[0]), .input_discard_flag(ev[1]), .query_lost(ev[2]),
        .dev_err(ev[3]), .exec_err(ev[4]), .cmd_err(ev[5]), .button_press(ev[6]),
        .power_on_evt(ev[7]), .comm_err_evt(comm_err_evt), .ovl_cond(ovl_cond),
        .in_buf_empty(in_buf_empty), .parser_idle(parser_idle),
        .token_mode_wr(token_mode_wr), .token_mode_val(token_mode_val),
        .term_wr(term_wr), .term_val(term_val),
        .token_keyword_mode(token_keyword_mode), .term_len(term_len),
        .term_char0(term_char0), .term_char1(term_char1), .status_summary_byte(sb),
        .overload_summary_bit(ovl_sum), .comm_error_summary_bit(cerr_sum),
        .status_req_n(status_req_n));
    srm_host_model srm_host_model_i (.core_clk(core_clk), .rd_data(rd_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_bit_en(rd_bit_en), .reg_sel(reg_sel),
        .bit_sel(bit_sel), .wr_data(wr_data), .cls_cmd(cls_cmd),
        .token_mode_wr(token_mode_wr), .token_mode_val(token_mode_val),
        .term_wr(term_wr), .term_val(term_val));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Status byte with the master summary worked out from the request mask
    function automatic logic [7:0] exp_sb(input logic idle, input logic esb,
                                          input logic [7:0] svc_mask);
        logic [7:0] b;
        b = {1'b0, 1'b0, esb, idle, 4'h0};
        b[6] = |(b & svc_mask & 8'hBF);
        return b;
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic pulse_ev(input logic [7:0] v);
        @(posedge core_clk);
        #1;
        ev = v;
        @(posedge core_clk);
        #1;
        ev = 8'h00;
    endtask
    task automatic end_test(input string name);
        $display("Test %s done, %0d compared, %0d mismatches", name, n_compared, miscompares);
    endtask
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        {ev, comm_err_evt, ovl_cond} = 24'h000000;
        {in_buf_empty, parser_idle} = 2'b11;
        {miscompares, n_compared} = 0;
        lfsr = 32'h0F81;
        repeat (12) @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk_bit(status_req_n, 1'b1);
        chk_bit(token_keyword_mode, 1'b0);
        chk_byte({6'h00, term_len}, 8'h02);
        chk_byte(term_char0, 8'h0D);
        chk_byte(term_char1, 8'h0A);
        chk_byte(sb, 8'h10);
        for (k = 1; k < 8; k += 2) begin
            srm_host_model_i.issue(1, 3'(k), 8'h00, q);
            chk_byte(q, 8'h00);
        end
        end_test("reset");
        for (k = 0; k < 6; k++) begin
            srm_host_model_i.issue(5, 3'h0, 8'(k), q);
            t = (k < 5) ? 3'(k) : 3'h4;
            chk_byte({6'h00, term_len}, (t == 0) ? 8'h00 : (t < 3) ? 8'h01 : 8'h02);
            if (t != 0) chk_byte(term_char0, (t == 1 || t == 3) ? 8'h0D : 8'h0A);
            if (t > 2) chk_byte(term_char1, (t == 3) ? 8'h0A : 8'h0D);
        end
        for (k = 1; k >= 0; k--) begin
            srm_host_model_i.issue(4, 3'h0, 8'(k), q);
            chk_bit(token_keyword_mode, k[0]);
        end
        srm_host_model_i.issue(0, `SRM_SEL_SVCMASK, 8'hFF, q);
        srm_host_model_i.issue(1, `SRM_SEL_SVCMASK, 8'h00, q);
        chk_byte(q, 8'hBF);
        srm_host_model_i.issue(0, `SRM_SEL_SVCMASK, 8'h00, q);
        end_test("format");
        for (k = 0; k < 8; k++) begin
            pulse_ev(8'h01 << k);
            srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
            chk_byte(q, 8'h01 << k);
            srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
            chk_byte(q, 8'h00);
        end
        pulse_ev(8'h03);
        srm_host_model_i.issue(2, `SRM_SEL_STDEV, 8'h00, q);
        srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
        chk_byte(q, 8'h02);
        pulse_ev(8'hFF);
        srm_host_model_i.issue(3, 3'h0, 8'h00, q);
        srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
        chk_byte(q, 8'h00);
        end_test("events");
        for (k = 0; k < 24; k++) begin
            lfsr = lfsr_next(lfsr);
            ese = lfsr[7:0];
            srm_host_model_i.issue(0, `SRM_SEL_ESE, ese, q);
            {in_buf_empty, parser_idle} = lfsr[9:8];
            pulse_ev(lfsr[23:16]);
            chk_byte(sb, exp_sb(&lfsr[9:8], |(ese & lfsr[23:16]), 8'h00));
            srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
            chk_bit(sb[5], 1'b0);
        end
        {in_buf_empty, parser_idle} = 2'b11;
        end_test("summary");
        srm_host_model_i.issue(0, `SRM_SEL_SVCMASK, 8'h20, q);
        srm_host_model_i.issue(0, `SRM_SEL_ESE, 8'h01, q);
        pulse_ev(8'h01);
        for (k = 0; k < 4 && status_req_n !== 1'b0; k++) begin
            @(posedge core_clk);
            #1;
        end
        chk_bit(status_req_n, 1'b0);
        srm_host_model_i.issue(1, `SRM_SEL_STB, 8'h00, q);
        chk_byte(q, exp_sb(1'b1, 1'b1, 8'h20));
        repeat (3) @(posedge core_clk);
        chk_bit(status_req_n, 1'b1);
        chk_byte(sb, 8'h70);
        pulse_ev(8'h01);
        repeat (2) @(posedge core_clk);
        chk_bit(status_req_n, 1'b1);
        srm_host_model_i.issue(1, `SRM_SEL_STDEV, 8'h00, q);
        @(posedge core_clk);
        chk_byte(sb, 8'h10);
        end_test("request");
        srm_host_model_i.issue(0, `SRM_SEL_OVEN, 8'hFF, q);
        ovl_cond = 8'h04;
        repeat (2) @(posedge core_clk);
        #1;
        ovl_cond = 8'h00;
        repeat (2) @(posedge core_clk);
        chk_bit(ovl_sum, 1'b1);
        chk_bit(sb[0], 1'b1);
        srm_host_model_i.issue(1, `SRM_SEL_OVSR, 8'h00, q);
        chk_byte(q, 8'h04);
        chk_bit(ovl_sum, 1'b0);
        srm_host_model_i.issue(0, `SRM_SEL_CEEN, 8'h10, q);
        @(posedge core_clk);
        #1;
        comm_err_evt = 8'h21;
        @(posedge core_clk);
        #1;
        comm_err_evt = 8'h00;
        chk_bit(cerr_sum, 1'b0);
        srm_host_model_i.issue(1, `SRM_SEL_CESR, 8'h00, q);
        chk_byte(q, 8'h21);
        comm_err_evt = 8'h30;
        @(posedge core_clk);
        #1;
        comm_err_evt = 8'h00;
        chk_bit(cerr_sum, 1'b1);
        chk_bit(sb[7], 1'b1);
        end_test("overload");
        complete_run();
    end
endmodule
`default_nettype wire
